// file: rtl/cfgld_cfg.svh
// Constants of the configuration loader: rule summary, sizes, counts and field positions.
// Summary of operation
// - Host parameter writes update working RAM only; flash unchanged until commit.
// - Commit command copies the whole working configuration from RAM into flash.
// - Factory configuration: outputs released, fast PWM low, no sequencing or faults.
// - Test port disabled by default; shared pins serve as general I/O.
// - Test port enabled at power-up when flash holds no configuration.
// - Test port enabled at power-up when decoded address equals 126.
// - System clock runs at ninety percent while test port mode is active.
// - Four of six test port pins usable as I/O when port disabled.
// - Test port supports programming only, no boundary scan.
// - Firmware checksum checked at power-up; mismatch blocks firmware, bus stays alive.
// - Configuration checksum mismatch loads factory defaults instead.
// - Configuration checksum failure asserts alert low and sets a status flag.
// - Separate checksum over error-log region detects fault log corruption.
// - Watchdog expiry triggers a normal device reset.
// - In reset, general I/O released and fast PWM driven low.
// - Every parameter is range checked.
// - Each flash write stores six check bits with each 32-bit word.
// - Each flash read corrects any single-bit error before delivery.
// - After in-operation rewrite, run old configuration with logging off until reset; logging stays on after test-port rewrites.
// - Full flash image accepted over the serial link or the test port.
// - About 20 ms initialisation after reset, fast PWM low, other I/O open.
`ifndef CFGLD_CFG_SVH
`define CFGLD_CFG_SVH
`define CFGLD_WORDS        16
`define CFGLD_AW           4
`define CFGLD_NGPIO        8
`define CFGLD_NFPWM        8
`define CFGLD_JTAG_ADDR    7'h7e
`define CFGLD_INIT_MS      20
`define CFGLD_CLK_MHZ      200
`define CFGLD_INIT_CYC     (`CFGLD_INIT_MS * 1000 * `CFGLD_CLK_MHZ)
`define CFGLD_SLOW_NUM     4'h9
`define CFGLD_SLOW_DEN     4'ha
`define CFGLD_WDT_CYC      200000
`define CFGLD_FW_IDX       0
`define CFGLD_LOG_IDX      1
`define CFGLD_CFG_IDX      2
`define CFGLD_PAR_FIRST    3
`define CFGLD_BLANK        38'h3f_ffff_ffff
`endif

// file: rtl/cfgld_pkg.sv
// Types shared by the configuration loader.
package cfgld_pkg;
  typedef struct packed {
    logic        we;
    logic [3:0]  addr;
    logic [31:0] data;
  } cfgld_req_t;
  typedef struct packed {
    logic        we;
    logic [3:0]  addr;
    logic [37:0] code;
  } cfgld_flash_t;
  typedef enum logic [6:0] {
    CFGLD_POR   = 7'b0000001,
    CFGLD_LOAD  = 7'b0000010,
    CFGLD_CHECK = 7'b0000100,
    CFGLD_INIT  = 7'b0001000,
    CFGLD_RUN   = 7'b0010000,
    CFGLD_HALT  = 7'b0100000,
    CFGLD_STORE = 7'b1000000
  } cfgld_state_t;
endpackage

// file: rtl/cfgld_top.sv
// Configuration store with checksum checks, flash ECC and test-port enable decision.
`timescale 1ns/1ps
`default_nettype none
`include "cfgld_cfg.svh"
module cfgld_top
  import cfgld_pkg::*;
#(
  parameter int unsigned INIT_CYC = `CFGLD_INIT_CYC,
  parameter int unsigned WDT_CYC  = `CFGLD_WDT_CYC
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_tck,
  input  wire logic [6:0]              i_bus_addr,
  input  wire logic                    i_addr_fault,
  input  wire cfgld_req_t              i_par,
  input  wire logic                    i_commit,
  input  wire logic                    i_unprotect,
  input  wire logic                    i_erase,
  input  wire cfgld_req_t              i_img,
  input  wire cfgld_req_t              i_tap_img,
  input  wire logic                    i_wdt_kick,
  input  wire logic [`CFGLD_NGPIO-1:0] i_gpio_val,
  input  wire logic [`CFGLD_NGPIO-1:0] i_gpio_oe,
  input  wire logic [`CFGLD_NFPWM-1:0] i_fast_pwm_output_val,
  input  wire logic [3:0]              i_tap_out,
  output logic [`CFGLD_NGPIO-1:0]      o_general_output,
  output logic [`CFGLD_NGPIO-1:0]      o_general_output_oe,
  output logic [`CFGLD_NFPWM-1:0]      o_fast_pwm_output,
  output logic                         o_alert_out_n,
  output logic                         o_cfg_crc_err,
  output logic                         o_fw_crc_err,
  output logic                         o_log_crc_err,
  output logic                         o_fw_run,
  output logic                         o_log_en,
  output logic                         o_tap_en,
  output logic                         o_clk_slow_en,
  output logic                         o_par_reject,
  output logic                         o_ecc_corrected,
  output logic                         o_busy,
  output logic                         o_wdt_rst
);
  // ----------------------------------------------------------------
  // ECC helpers.
  // ----------------------------------------------------------------
  // Six check bits of a Hamming code over positions 1 to 38: check bits sit at the
  // powers of two and data bits fill the other positions in order, so every single
  // flipped bit, data or check, gives its own nonzero syndrome.
  function automatic logic [5:0] cfgld_ecc_gen(input logic [31:0] d);
    logic [5:0] c;
    int         k;
    c = 6'h00;
    k = 0;
    for (int p = 3; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 6; b++) begin
          if (((p >> b) & 1) == 1) c[b] = c[b] ^ d[k];
        end
        k++;
      end
    end
    return c;
  endfunction
  // Correct a single-bit data error; a check-bit error needs no data change.
  // The top bit reports that a data bit was actually flipped.
  function automatic logic [32:0] cfgld_ecc_fix(input logic [37:0] w);
    logic [5:0]  s;
    logic [31:0] d;
    logic        hit;
    int          k;
    s   = cfgld_ecc_gen(w[31:0]) ^ w[37:32];
    d   = w[31:0];
    hit = 1'b0;
    k   = 0;
    for (int p = 3; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (6'(p) == s) begin
          d[k] = ~d[k];
          hit  = 1'b1;
        end
        k++;
      end
    end
    return {hit, d};
  endfunction

  // ----------------------------------------------------------------
  // Link domain: test-port image writes crossed with a toggle.
  // ----------------------------------------------------------------
  cfgld_req_t tap_hold_r;
  logic       tap_tgl_r;
  logic [2:0] tap_sync_r;
  logic       tap_en_r;
  // Hold stays stable long enough because writes are slow relative to i_clk.
  // The enable is applied on the system side only: the link clock stands still
  // between frames, so an enable synchronised to it would lag and drop words.
  always_ff @(posedge i_tck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tap_hold_r <= '0;
      tap_tgl_r  <= 1'b0;
    end else if (i_tap_img.we) begin
      tap_hold_r <= i_tap_img;
      tap_tgl_r  <= ~tap_tgl_r;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) tap_sync_r <= 3'b000;
    else tap_sync_r <= {tap_sync_r[1:0], tap_tgl_r};
  end
  wire logic tap_evt = tap_sync_r[2] ^ tap_sync_r[1];

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [15:0] pin_s1_r;
  logic [15:0] pin_s2_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
    end else begin
      pin_s1_r <= {7'h00, i_wdt_kick, i_addr_fault, i_bus_addr};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire logic [6:0] addr_s  = pin_s2_r[6:0];
  wire logic       afault_s = pin_s2_r[7];
  wire logic       kick_s  = pin_s2_r[8];

  // ----------------------------------------------------------------
  // Storage: working RAM and ECC-protected flash.
  // ----------------------------------------------------------------
  logic [31:0] ram_r   [`CFGLD_WORDS];
  // The flash array is nonvolatile, so it starts out erased rather than reset.
  logic [37:0] flash_r [`CFGLD_WORDS] = '{default: `CFGLD_BLANK};
  cfgld_state_t state_r;
  logic [`CFGLD_AW:0] idx_r;
  logic [31:0] sum_r;
  logic [31:0] cfg_word_r;
  logic        blank_r;
  logic        prot_off_r;
  logic        rewritten_r;
  logic [32:0] rd_fix;
  assign rd_fix = cfgld_ecc_fix(flash_r[idx_r[`CFGLD_AW-1:0]]);

  // Parameter range: the top nibble must be zero for parameter words.
  wire logic par_ok = (i_par.addr >= 4'(`CFGLD_PAR_FIRST)) && (i_par.data[31:28] == 4'h0);
  wire logic run_st = (state_r == CFGLD_RUN);
  // A halted device still takes flash maintenance commands from the host.
  wire logic host_st = run_st || (state_r == CFGLD_HALT);

  // Host writes go to RAM only; rejected writes keep the old value.
  always_ff @(posedge i_clk) begin
    if (state_r == CFGLD_LOAD && idx_r < 5'(`CFGLD_WORDS)) begin
      ram_r[idx_r[`CFGLD_AW-1:0]] <= rd_fix[31:0];
    // The checksum verdict settles at the end of CHECK, so defaults land during INIT.
    end else if (state_r == CFGLD_INIT && o_cfg_crc_err) begin
      for (int i = `CFGLD_PAR_FIRST; i < `CFGLD_WORDS; i++) ram_r[i] <= 32'h0000_0000;
    end else if (run_st && i_par.we && par_ok) begin
      ram_r[i_par.addr] <= i_par.data;
    end
  end

  // Flash writes: commit copies RAM, image writes come from link or test port.
  always_ff @(posedge i_clk) begin
    if (state_r == CFGLD_STORE && idx_r < 5'(`CFGLD_WORDS)) begin
      flash_r[idx_r[`CFGLD_AW-1:0]] <= {cfgld_ecc_gen(ram_r[idx_r[`CFGLD_AW-1:0]]),
                                        ram_r[idx_r[`CFGLD_AW-1:0]]};
    end else if (host_st && prot_off_r && i_erase) begin
      for (int i = 0; i < `CFGLD_WORDS; i++) flash_r[i] <= `CFGLD_BLANK;
    end else if (host_st && prot_off_r && i_img.we) begin
      flash_r[i_img.addr] <= {cfgld_ecc_gen(i_img.data), i_img.data};
    end else if (tap_evt && tap_en_r) begin
      flash_r[tap_hold_r.addr] <= {cfgld_ecc_gen(tap_hold_r.data), tap_hold_r.data};
    end
  end

  // ----------------------------------------------------------------
  // Power-up sequencer.
  // ----------------------------------------------------------------
  logic [31:0] cnt_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= CFGLD_POR;
      idx_r   <= '0;
      cnt_r   <= 32'h0;
      sum_r   <= 32'h0;
      blank_r <= 1'b1;
    end else if (o_wdt_rst) begin
      // Watchdog expiry restarts the whole power-up sequence.
      state_r <= CFGLD_POR;
    end else begin
      case (state_r)
        CFGLD_POR: begin
          idx_r   <= '0;
          sum_r   <= 32'h0;
          blank_r <= 1'b1;
          state_r <= CFGLD_LOAD;
        end
        CFGLD_LOAD: begin
          if (idx_r < 5'(`CFGLD_WORDS)) begin
            if (flash_r[idx_r[`CFGLD_AW-1:0]] != `CFGLD_BLANK) blank_r <= 1'b0;
            if (idx_r >= 5'(`CFGLD_PAR_FIRST)) sum_r <= sum_r + rd_fix[31:0];
            idx_r <= idx_r + 5'd1;
          end else begin
            state_r <= CFGLD_CHECK;
          end
        end
        CFGLD_CHECK: begin
          cnt_r   <= 32'h0;
          state_r <= CFGLD_INIT;
        end
        CFGLD_INIT: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= INIT_CYC - 1) state_r <= o_fw_crc_err ? CFGLD_HALT : CFGLD_RUN;
        end
        CFGLD_RUN: begin
          if (i_commit) begin
            idx_r   <= '0;
            state_r <= CFGLD_STORE;
          end
        end
        CFGLD_STORE: begin
          if (idx_r < 5'(`CFGLD_WORDS)) idx_r <= idx_r + 5'd1;
          else state_r <= CFGLD_RUN;
        end
        CFGLD_HALT: state_r <= CFGLD_HALT;
        default:    state_r <= CFGLD_POR;
      endcase
    end
  end

  // Checksum results, sampled while the image streams past.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fw_crc_err  <= 1'b0;
      o_log_crc_err <= 1'b0;
      o_cfg_crc_err <= 1'b0;
      o_ecc_corrected <= 1'b0;
      cfg_word_r      <= 32'h0000_0000;
    end else if (state_r == CFGLD_POR) begin
      o_ecc_corrected <= 1'b0;
    end else if (state_r == CFGLD_LOAD && idx_r < 5'(`CFGLD_WORDS)) begin
      o_ecc_corrected <= o_ecc_corrected | rd_fix[32];
      if (idx_r == 5'(`CFGLD_CFG_IDX)) cfg_word_r <= rd_fix[31:0];
      if (idx_r == 5'(`CFGLD_FW_IDX)) o_fw_crc_err <= (rd_fix[31:0] != 32'h0000_0000);
      if (idx_r == 5'(`CFGLD_LOG_IDX)) o_log_crc_err <= (rd_fix[31:0] != 32'h0000_0000);
    end else if (state_r == CFGLD_CHECK) begin
      // Blank flash is not a corrupt image, so it is not flagged.
      o_cfg_crc_err <= ~blank_r && (sum_r != cfg_word_r);
    end
  end

  // Test-port decision, latched once after the strap pins settle.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) tap_en_r <= 1'b0;
    else if (state_r == CFGLD_CHECK) begin
      tap_en_r <= blank_r || afault_s || (addr_s == `CFGLD_JTAG_ADDR);
    end
  end

  // Write protection and rewrite tracking.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prot_off_r  <= 1'b0;
      rewritten_r <= 1'b0;
    end else if (state_r == CFGLD_POR) begin
      // A watchdog restart is a normal reset and re-arms protection and logging.
      prot_off_r  <= 1'b0;
      rewritten_r <= 1'b0;
    end else if (host_st) begin
      if (i_unprotect) prot_off_r <= 1'b1;
      if (prot_off_r && (i_erase || i_img.we)) rewritten_r <= 1'b1;
    end
  end

  // Watchdog: expiry pulses a reset request outward.
  logic [31:0] wdt_r;
  logic        kick_d_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wdt_r     <= 32'h0;
      kick_d_r  <= 1'b0;
      o_wdt_rst <= 1'b0;
    end else begin
      kick_d_r  <= kick_s;
      o_wdt_rst <= 1'b0;
      if (!run_st || (kick_s ^ kick_d_r)) wdt_r <= 32'h0;
      else if (wdt_r >= WDT_CYC - 1) begin
        wdt_r     <= 32'h0;
        o_wdt_rst <= 1'b1;
      end else wdt_r <= wdt_r + 32'h1;
    end
  end

  // Ninety-percent clock gate: nine enables out of every ten cycles.
  logic [3:0] slow_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) slow_r <= 4'h0;
    else slow_r <= (slow_r == `CFGLD_SLOW_DEN - 4'h1) ? 4'h0 : slow_r + 4'h1;
  end

  // Pin outputs; registered so they never glitch.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_general_output    <= '0;
      o_general_output_oe <= '0;
      o_fast_pwm_output   <= '0;
      o_alert_out_n       <= 1'b1;
      o_par_reject        <= 1'b0;
      o_clk_slow_en       <= 1'b1;
    end else begin
      o_par_reject  <= run_st && i_par.we && !par_ok;
      o_alert_out_n <= ~o_cfg_crc_err;
      o_clk_slow_en <= ~tap_en_r || (slow_r < `CFGLD_SLOW_NUM);
      // Commit keeps the pins as they are; a watchdog expiry drops them at once.
      if (o_fw_run && !o_wdt_rst && !blank_r && !o_cfg_crc_err) begin
        o_fast_pwm_output   <= i_fast_pwm_output_val;
        o_general_output    <= i_gpio_val;
        // Upper four pins follow the test port when it owns them.
        o_general_output_oe <= tap_en_r ? {4'hf, i_gpio_oe[3:0]} : i_gpio_oe;
        if (tap_en_r) o_general_output[7:4] <= i_tap_out;
      end else begin
        o_fast_pwm_output   <= '0;
        o_general_output    <= '0;
        o_general_output_oe <= tap_en_r ? 8'hf0 : 8'h00;
        if (tap_en_r) o_general_output[7:4] <= i_tap_out;
      end
    end
  end

  assign o_tap_en = tap_en_r;
  assign o_fw_run = run_st || (state_r == CFGLD_STORE);
  assign o_log_en = o_fw_run && !rewritten_r;
  assign o_busy   = !run_st;
endmodule
`default_nettype wire

// file: testbench/cfgld_asserts.sv
// Concurrent checks on the configuration loader's ports.
`timescale 1ns/1ps
`default_nettype none
module cfgld_asserts
  import cfgld_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire cfgld_req_t i_par,
  input wire logic       i_commit,
  input wire logic [7:0] o_general_output_oe,
  input wire logic [7:0] o_fast_pwm_output,
  input wire logic       o_alert_out_n,
  input wire logic       o_cfg_crc_err,
  input wire logic       o_fw_crc_err,
  input wire logic       o_fw_run,
  input wire logic       o_log_en,
  input wire logic       o_tap_en,
  input wire logic       o_clk_slow_en,
  input wire logic       o_par_reject,
  input wire logic       o_busy,
  input wire logic       o_wdt_rst
);
  // ----------------------------------------
  // Checks on the system clock
  // ----------------------------------------
  // Every check sleeps through reset, since flags and pins are forced there.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic bad_par;
  assign bad_par = i_par.addr < 4'h3 || i_par.data[31:28] != 4'h0;  // Range test of a write.
  chk_idle_pins: assert property (
    o_busy && !o_fw_run |-> o_fast_pwm_output == 8'h00 && o_general_output_oe[3:0] == 4'h0)
    else $error("pins driven while not running");
  chk_bad_refused: assert property (
    i_par.we && !o_busy && bad_par |-> ##[1:2] o_par_reject)
    else $error("bad write not refused");
  chk_good_taken: assert property (
    i_par.we && !o_busy && !bad_par |-> ##1 !o_par_reject ##1 !o_par_reject)
    else $error("good write refused");
  chk_tap_held: assert property (
    !o_busy |-> $stable(o_tap_en))
    else $error("test port changed in run");
  chk_slow_only_tap: assert property (
    !o_clk_slow_en |-> o_tap_en)
    else $error("clock slowed without test port");
  chk_slow_ratio: assert property (
    $fell(o_clk_slow_en) |=> o_clk_slow_en [*8] ##1 o_clk_slow_en ##1 !o_clk_slow_en)
    else $error("slow clock not nine of ten");
  chk_cfg_alert: assert property (
    o_cfg_crc_err |-> ##[0:1] !o_alert_out_n)
    else $error("alert missing on config error");
  chk_fw_halt: assert property (
    o_fw_crc_err |-> !o_fw_run && !o_log_en)
    else $error("firmware runs despite bad checksum");
  chk_commit_busy: assert property (
    i_commit && !o_busy |=> o_busy [*8])
    else $error("commit did not hold busy");
  chk_wdt_restart: assert property (
    o_wdt_rst |-> ##[0:2] o_busy)
    else $error("watchdog did not restart");
endmodule
bind cfgld_top cfgld_asserts u_chk (.i_clk, .i_sys_rst, .i_par, .i_commit, .o_general_output_oe,
  .o_fast_pwm_output, .o_alert_out_n, .o_cfg_crc_err, .o_fw_crc_err, .o_fw_run, .o_log_en,
  .o_tap_en, .o_clk_slow_en, .o_par_reject, .o_busy, .o_wdt_rst);
`default_nettype wire

// file: testbench/cfgld_tap_host.sv
// Test-port programmer model that writes image words on its own clock.
`timescale 1ns/1ps
`default_nettype none
module cfgld_tap_host
  import cfgld_pkg::*;
(
  output logic       o_tck,
  output cfgld_req_t o_tap_img
);
  // ----------------------------------------
  // Word writer
  // ----------------------------------------
  // The clock stands still between frames; released lines show inverted data so stale
  // values can never pass for a fresh word.
  initial begin
    o_tck = 1'b0;
    o_tap_img = '0;
  end
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    o_tap_img = '{we: 1'b1, addr: a, data: d};
    #24 o_tck = 1'b1;
    #24 o_tck = 1'b0;
    o_tap_img = '{we: 1'b0, addr: ~a, data: ~d};
    repeat (2) begin
      #24 o_tck = 1'b1;
      #24 o_tck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the configuration loader.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cfgld_pkg::*;
  logic        i_clk, i_sys_rst, i_tck, i_addr_fault, i_commit, i_unprotect, i_erase;
  logic        i_wdt_kick, kick_on, o_alert_out_n, o_cfg_crc_err, o_fw_crc_err;
  logic        o_log_crc_err, o_fw_run, o_log_en, o_tap_en, o_clk_slow_en, o_par_reject;
  logic        o_ecc_corrected, o_busy, o_wdt_rst;
  logic [6:0]  i_bus_addr;
  logic [3:0]  i_tap_out;
  logic [7:0]  i_gpio_val, i_gpio_oe, i_fast_pwm_output_val, o_general_output, o_general_output_oe;
  logic [7:0]  o_fast_pwm_output;
  logic [31:0] img [16];
  cfgld_req_t  i_par, i_img, i_tap_img;
  logic        exp_q [$];
  int          errors, check_count, cyc;
  cfgld_top #(.INIT_CYC(50), .WDT_CYC(100)) DUT (
    .i_clk, .i_sys_rst, .i_tck, .i_bus_addr, .i_addr_fault, .i_par, .i_commit,
    .i_unprotect, .i_erase, .i_img, .i_tap_img, .i_wdt_kick, .i_gpio_val, .i_gpio_oe,
    .i_fast_pwm_output_val, .i_tap_out, .o_general_output, .o_general_output_oe,
    .o_fast_pwm_output, .o_alert_out_n, .o_cfg_crc_err, .o_fw_crc_err, .o_log_crc_err,
    .o_fw_run, .o_log_en, .o_tap_en, .o_clk_slow_en, .o_par_reject, .o_ecc_corrected,
    .o_busy, .o_wdt_rst);
  cfgld_tap_host u_tap (.o_tck(i_tck), .o_tap_img(i_tap_img));
  // ----------------------------------------
  // Clock, timeout and watchdog kicks
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // The ceiling is several times the expected run length.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  // A gap in kicks longer than the watchdog count would reset the device mid-test.
  initial begin
    i_wdt_kick = 1'b0;
    forever begin
      repeat (20) @(negedge i_clk);
      if (kick_on) i_wdt_kick = ~i_wdt_kick;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_run();
    for (int n = 0; n < 400 && o_busy !== 1'b0; n++) @(negedge i_clk);
  endtask
  task automatic boot();
    @(negedge i_clk) i_sys_rst = 1'b1;
    repeat (12) @(negedge i_clk);
    check({o_fast_pwm_output, o_general_output_oe}, 16'h0, "pins in reset");
    i_sys_rst = 1'b0;
    wait_run();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic stat(input logic [3:0] exp);
    check({o_tap_en, o_cfg_crc_err, o_fw_crc_err, o_log_crc_err}, exp, "status flags");
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1'b1;
    @(negedge i_clk) s = 1'b0;
  endtask
  task automatic par(input logic [3:0] a, input logic [31:0] d, input logic bad);
    @(negedge i_clk) i_par = '{we: 1'b1, addr: a, data: d};
    exp_q.push_back(bad);
    @(negedge i_clk) i_par.we = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic link(input logic [3:0] a, input logic [31:0] d);
    wait_run();
    @(negedge i_clk) i_img = '{we: 1'b1, addr: a, data: d};
    @(negedge i_clk) i_img = '{we: 1'b0, addr: ~a, data: ~d};
  endtask
  // Words 0 and 1 hold the check words, word 2 the sum of the parameters plus a bias.
  task automatic mk(input logic [31:0] fw, input logic [31:0] bias);
    img[0] = fw;
    img[1] = fw;
    img[2] = bias;
    for (int k = 3; k < 16; k++) begin
      img[k] = {4'h0, 28'($urandom)};
      img[2] += img[k];
    end
  endtask
  // Watches the refusal flag over the few cycles after each host write.
  initial begin
    logic seen;
    forever begin
      @(posedge i_clk);
      if (i_par.we === 1'b1) begin
        seen = 1'b0;
        repeat (3) begin
          @(negedge i_clk);
          seen = seen | o_par_reject;
        end
        check(seen, exp_q.pop_front(), "write refusal");
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h0b31));
    {i_addr_fault, i_commit, i_unprotect, i_erase} = 4'h0;
    {i_par, i_img} = '0;
    {i_sys_rst, kick_on} = 2'b11;
    i_bus_addr = 7'h21;
    i_tap_out = 4'h9;
    i_gpio_val = 8'($urandom);
    i_gpio_oe = 8'($urandom);
    i_fast_pwm_output_val = 8'($urandom);
    boot();
    // Blank flash holds no valid firmware or log check word, so the device halts.
    stat(4'b1011);
    check(o_general_output[7:4], 4'h9, "test port pins");
    check(o_ecc_corrected, 1'b0, "no correction");
    mk(32'h0, 32'h0);
    for (int k = 0; k < 16; k++) u_tap.put(4'(k), img[k]);
    boot();
    stat(4'b0000);
    check({o_alert_out_n, o_fw_run, o_log_en}, 3'b111, "run flags");
    check({o_general_output, o_general_output_oe}, {i_gpio_val, i_gpio_oe}, "gpio");
    check(o_fast_pwm_output, i_fast_pwm_output_val, "fast pwm");
    par(4'h2, 32'h5, 1'b1);
    par(4'h5, 32'h1000_0000, 1'b1);
    par(4'h5, {4'h0, 28'($urandom)}, 1'b0);
    par(4'hf, 32'h0fff_ffff, 1'b0);
    boot();
    stat(4'b0000);
    pulse(i_erase);
    link(4'h3, 32'h1);
    boot();
    stat(4'b0000);
    pulse(i_unprotect);
    pulse(i_erase);
    mk(32'h0, 32'h5);
    for (int k = 0; k < 16; k++) link(4'(k), img[k]);
    check({o_fw_run, o_log_en}, 2'b10, "logging after rewrite");
    boot();
    stat(4'b0100);
    check(o_alert_out_n, 1'b0, "alert");
    check({o_fast_pwm_output, o_general_output_oe}, 16'h0, "factory pins");
    pulse(i_unprotect);
    pulse(i_erase);
    mk(32'h1, 32'h0);
    for (int k = 0; k < 16; k++) link(4'(k), img[k]);
    boot();
    stat(4'b0011);
    check(o_fw_run, 1'b0, "firmware halted");
    i_bus_addr = 7'h7e;
    boot();
    stat(4'b1011);
    mk(32'h0, 32'h0);
    for (int k = 0; k < 16; k++) u_tap.put(4'(k), img[k]);
    i_bus_addr = 7'h21;
    i_addr_fault = 1'b1;
    boot();
    stat(4'b1000);
    i_addr_fault = 1'b0;
    boot();
    stat(4'b0000);
    par(4'h5, img[5] ^ 32'h1, 1'b0);
    pulse(i_commit);
    repeat (40) @(negedge i_clk);
    kick_on = 1'b0;
    for (int n = 0; n < 300 && o_wdt_rst !== 1'b1; n++) @(negedge i_clk);
    check(o_wdt_rst, 1'b1, "watchdog reset");
    // The restart reloads the committed image, whose sum no longer matches.
    repeat (2) @(negedge i_clk);
    wait_run();
    stat(4'b0100);
    print_verdict();
  end
endmodule
`default_nettype wire
